// ### comm_intr_ctrl.sv
// Communication interrupt controller: registers, acknowledge handling and vector output.
`default_nettype none

module comm_intr_ctrl #(
    parameter int NUM_SRC = 32
) (
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output var  logic [31:0] avs_readdata_o,
    output var  logic        avs_waitrequest_o,
    input  wire logic [31:0] src_event_i,
    input  wire logic        iack_i,
    input  wire logic [2:0]  iack_level_i,
    output var  logic [2:0]  irq_level_o,
    output var  logic [7:0]  vector_o,
    output var  logic        vector_valid_o
);
    // ==================================================================
    // Elaboration checks
    // ==================================================================
    generate
        if (NUM_SRC != comm_intr_pkg::NUM_SRC) begin : g_bad_num
            $error("comm_intr_ctrl serves exactly 32 sources");
        end
    endgenerate

    // ==================================================================
    // State
    // ==================================================================
    typedef struct packed {
        logic [23:0] cfg;
        logic        base_written;
        logic [31:0] pending;
        logic [31:0] mask;
        logic [31:0] in_service;
        logic        wait_req;
        logic [31:0] rdata;
        logic [2:0]  irq_level;
        logic [7:0]  vector;
        logic        vector_valid;
    } state_t;

    state_t s;
    state_t next_s;

    prio_sel_if ps ();

    comm_intr_prio_sel u_sel (
        .ps (ps)
    );

    assign ps.pending    = s.pending;
    assign ps.mask       = s.mask;
    assign ps.in_service = s.in_service;
    assign ps.cfg        = s.cfg;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction : lane_mask

    function automatic logic [31:0] one_hot(input logic [4:0] code);
        return 32'h00000001 << code;
    endfunction : one_hot

    // ==================================================================
    // Next-state logic
    // ==================================================================
    logic [2:0]  level;
    logic        take;
    logic        bus_commit;
    logic [31:0] wmask;
    logic [31:0] w1c;

    always_comb begin
        logic [31:0] ack_hot;
        logic [23:0] cfg_m;
        next_s     = s;
        ack_hot    = 32'h00000000;
        cfg_m      = 24'h000000;
        level      = s.cfg[comm_intr_pkg::LEVEL_LSB +: 3];
        take       = iack_i && level != comm_intr_pkg::LEVEL_OFF && iack_level_i == level;
        bus_commit = avs_write_i && !s.wait_req;
        wmask      = lane_mask(avs_byteenable_i);
        w1c        = avs_writedata_i & wmask;
        next_s.vector_valid = 1'b0;

        // One wait cycle, then the answer; a held request is never taken twice.
        if ((avs_read_i || avs_write_i) && s.wait_req) begin
            next_s.wait_req = 1'b0;
            case (avs_address_i)
                comm_intr_pkg::OFF_CONFIG:  next_s.rdata = {8'h00, s.cfg};
                comm_intr_pkg::OFF_PENDING: next_s.rdata = s.pending;
                comm_intr_pkg::OFF_MASK:    next_s.rdata = s.mask;
                comm_intr_pkg::OFF_IN_SVC:  next_s.rdata = s.in_service;
                default:                    next_s.rdata = 32'h00000000;
            endcase
        end else begin
            next_s.wait_req = 1'b1;
        end

        if (take) begin
            next_s.vector_valid = 1'b1;
            // vector assembly, error code when nothing qualifies
            next_s.vector = {s.cfg[comm_intr_pkg::BASE_LSB +: 3],
                             ps.found ? ps.code : comm_intr_pkg::CODE_ERROR};
            if (!s.base_written) begin
                next_s.vector = comm_intr_pkg::UNINIT_VECTOR;
            end
            if (ps.found) begin
                ack_hot = one_hot(ps.code);
            end
        end

        // Hardware sets win over software clears in the same cycle.
        if (bus_commit && avs_address_i == comm_intr_pkg::OFF_PENDING) begin
            next_s.pending = s.pending & ~w1c;
        end
        next_s.pending = (next_s.pending & ~ack_hot) | src_event_i;
        if (bus_commit && avs_address_i == comm_intr_pkg::OFF_IN_SVC) begin
            next_s.in_service = s.in_service & ~w1c;
        end
        next_s.in_service = next_s.in_service | ack_hot;
        if (bus_commit && avs_address_i == comm_intr_pkg::OFF_MASK) begin
            next_s.mask = (s.mask & ~wmask) | w1c;
        end
        // live configuration writes, reserved bits held at zero
        if (bus_commit && avs_address_i == comm_intr_pkg::OFF_CONFIG) begin
            cfg_m      = wmask[23:0] & comm_intr_pkg::CFG_WR_MASK;
            next_s.cfg = (s.cfg & ~cfg_m) | (avs_writedata_i[23:0] & cfg_m);
            if (avs_byteenable_i[0]) begin
                next_s.base_written = 1'b1;
            end
        end

        // request only for an unmasked winner at a nonzero level
        next_s.irq_level = ps.found ? level : comm_intr_pkg::LEVEL_OFF;
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s              <= '0;
            s.cfg          <= comm_intr_pkg::CFG_RESET;
            s.wait_req     <= 1'b1;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign avs_readdata_o    = s.rdata;
    assign avs_waitrequest_o = s.wait_req;
    assign irq_level_o       = s.irq_level;
    assign vector_o          = s.vector;
    assign vector_valid_o    = s.vector_valid;

    // ==================================================================
    // Assertions
    // ==================================================================
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    logic [4:0] top_src;
    assign top_src = s.cfg[comm_intr_pkg::TOP_LSB +: 5];

    a_level_zero_quiet: assert property (ce_i && level == 3'h0 |=> irq_level_o == 3'h0)
        else $error("request raised while level is zero");
    a_masked_no_req: assert property (ce_i && (s.pending & s.mask) == 32'h00000000
                                      |=> irq_level_o == 3'h0)
        else $error("request raised with no unmasked pending source");
    a_vector_base: assert property (ce_i && take && s.base_written
                                    |=> vector_o[7:5] == $past(s.cfg[7:5]))
        else $error("vector base bits wrong");
    a_uninit_vector: assert property (ce_i && take && !s.base_written
                                      |=> vector_o == 8'h0F)
        else $error("uninitialised vector not issued");
    a_error_vector: assert property (ce_i && take && s.base_written && !ps.found
                                     |=> vector_o[4:0] == 5'h00)
        else $error("error vector not issued");
    a_ack_answered: assert property (ce_i && take |=> vector_valid_o ##1 !vector_valid_o
                                     or (ce_i && take |=> vector_valid_o))
        else $error("acknowledge left without a vector");
    a_served_cleared: assert property (ce_i && take && ps.found && !src_event_i[ps.code]
                                       |=> !s.pending[$past(ps.code)]
                                           && s.in_service[$past(ps.code)])
        else $error("served source not retired");
    a_top_first: assert property (top_src != 5'h1F && s.mask[top_src] && s.pending[top_src]
                                  && !s.in_service[top_src]
                                  |-> ps.found && ps.code == top_src)
        else $error("top-priority source not selected");
    a_reserved_zero: assert property (s.cfg[4:1] == 4'h0)
        else $error("reserved configuration bits set");
    a_cfg_reset: assert property (disable iff (1'b0) srst_i |=> s.cfg == 24'h000000)
        else $error("configuration not cleared by reset");
    a_bus_answer: assert property (ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
                                   |=> !avs_waitrequest_o)
        else $error("bus request not answered in one cycle");

    c_vector_served: cover property (take && ps.found);
    c_error_served: cover property (take && !ps.found && s.base_written);
    c_spread_served: cover property (take && ps.found && s.cfg[0]);
    c_top_served: cover property (take && ps.found && ps.code == top_src && top_src != 5'h1F);
endmodule : comm_intr_ctrl

`default_nettype wire

// ### comm_intr_pkg.sv
// Constants shared by the communication interrupt controller and its priority selector.
// Notes on behaviour
// - Pending unmasked sources are served one at a time, highest priority first; sources 0, 8, 13 and 19 only when named as top priority.
// - Every acknowledge at the programmed level gets a vector when that level is nonzero, core active or not.
// - Vector is three base bits above five generated source bits.
// - Low codes: port line 0 is 11111, channels 11110 to 11011, error 00000.
// - Serial channel codes stay fixed whatever placement or channel order.
// - Error vector goes out when a raised request was masked and no unmasked source pends.
// - The full eight-bit vector is what the acknowledge cycle returns.
// - Configuration is 24 bits, read/write, zero after reset, changeable live.
// - Configuration fields: slots 23:16, level 15:13, top 12:8, base 7:5, placement 0.
// - Each two-bit slot field routes channel 1 to 4 into that slot.
// - Slot fields take effect as soon as they are rewritten.
// - A masked source raises no request but stays recorded as pending.
// - Level field sets request level; zero disables all requests.
// - Top-priority field names a source served first; 11111 keeps normal order.
// - Until the base bits are written, every vector reads as the uninitialised value.
// - Placement bit: 0 groups channels at the top, 1 spreads them.
`default_nettype none

package comm_intr_pkg;
    localparam int          NUM_SRC       = 32;
    localparam int          CODE_W        = 5;
    localparam int          CFG_W         = 24;
    // Register byte addresses on the register bus.
    localparam logic [4:0]  OFF_CONFIG    = 5'h00;
    localparam logic [4:0]  OFF_PENDING   = 5'h04;
    localparam logic [4:0]  OFF_MASK      = 5'h08;
    localparam logic [4:0]  OFF_IN_SVC    = 5'h0C;
    // Configuration field positions.
    localparam int          SLOT_A_LSB    = 16;
    localparam int          LEVEL_LSB     = 13;
    localparam int          TOP_LSB       = 8;
    localparam int          BASE_LSB      = 5;
    localparam int          PLACE_BIT     = 0;
    localparam logic [23:0] CFG_RESET     = 24'h000000;
    localparam logic [23:0] CFG_WR_MASK   = 24'hFFFFE1;
    // Source codes.
    localparam logic [4:0]  CODE_ERROR    = 5'h00;
    localparam logic [4:0]  CODE_NO_TOP   = 5'h1F;
    localparam logic [4:0]  CODE_CHAN1    = 5'h1E;
    localparam logic [7:0]  UNINIT_VECTOR = 8'h0F;
    localparam logic [2:0]  LEVEL_OFF     = 3'h0;
    // Table positions of slots a..d, grouped and spread.
    localparam logic [19:0] POS_GROUPED   = {5'h1B, 5'h1C, 5'h1D, 5'h1E};
    localparam logic [19:0] POS_SPREAD    = {5'h08, 5'h0D, 5'h13, 5'h1E};
endpackage : comm_intr_pkg

`default_nettype wire

// ### comm_intr_prio_sel.sv
// Combinational priority selection of the winning interrupt source.
`default_nettype none

module comm_intr_prio_sel (
    prio_sel_if.sel ps
);
    // ==================================================================
    // Mapping between source numbers and table positions
    // ==================================================================
    function automatic logic [4:0] slot_pos(input int k, input logic [23:0] cfg);
        logic [19:0] tbl;
        tbl = cfg[comm_intr_pkg::PLACE_BIT] ? comm_intr_pkg::POS_SPREAD
                                            : comm_intr_pkg::POS_GROUPED;
        return tbl[k*5 +: 5];
    endfunction : slot_pos

    function automatic logic [4:0] slot_src(input int k, input logic [23:0] cfg);
        logic [1:0] sel;
        sel = cfg[comm_intr_pkg::SLOT_A_LSB + 2*k +: 2];
        return comm_intr_pkg::CODE_CHAN1 - {3'h0, sel};
    endfunction : slot_src

    function automatic logic [31:0] to_pos(input logic [31:0] by_num,
                                           input logic [23:0] cfg);
        logic [31:0] r;
        r = by_num;
        for (int k = 0; k < 4; k++) begin
            r[comm_intr_pkg::POS_GROUPED[k*5 +: 5]] = 1'b0;
            r[comm_intr_pkg::POS_SPREAD[k*5 +: 5]]  = 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
            r[slot_pos(k, cfg)] = r[slot_pos(k, cfg)] | by_num[slot_src(k, cfg)];
        end
        return r;
    endfunction : to_pos

    // ==================================================================
    // Selection
    // ==================================================================
    logic [31:0] want_num;
    logic [31:0] want_pos;
    logic [31:0] svc_pos;
    logic [4:0]  top;

    always_comb begin
        logic blocked;
        logic [4:0] num;
        blocked   = 1'b0;
        num       = comm_intr_pkg::CODE_ERROR;
        want_num  = ps.pending & ps.mask;
        want_pos  = to_pos(want_num, ps.cfg);
        svc_pos   = to_pos(ps.in_service, ps.cfg);
        top       = ps.cfg[comm_intr_pkg::TOP_LSB +: 5];
        ps.found  = 1'b0;
        ps.code   = comm_intr_pkg::CODE_ERROR;
        for (int p = 31; p >= 1; p--) begin
            blocked = blocked | svc_pos[p];
            if (!ps.found && !blocked && want_pos[p]) begin
                ps.found = 1'b1;
                num      = 5'(p);
                for (int k = 0; k < 4; k++) begin
                    if (slot_pos(k, ps.cfg) == 5'(p)) begin
                        num = slot_src(k, ps.cfg);
                    end
                end
                ps.code = num;
            end
        end
        if (top != comm_intr_pkg::CODE_NO_TOP && want_num[top] && !ps.in_service[top]) begin
            ps.found = 1'b1;
            ps.code  = top;
        end
    end
endmodule : comm_intr_prio_sel

`default_nettype wire

// ### host_core_model.sv
// Host core model that answers interrupt requests with acknowledge cycles.
`default_nettype none

module host_core_model #(
    parameter logic [2:0] KICK_LEVEL = 3'h4
) (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       en_i,
    input  wire logic       slow_i,
    input  wire logic       wrong_i,
    input  wire logic       kick_i,
    input  wire logic [2:0] irq_level_i,
    input  wire logic [7:0] vector_i,
    input  wire logic       vector_valid_i,
    output var  logic       iack_o,
    output var  logic [2:0] iack_level_o,
    output var  logic [7:0] last_vector_o,
    output var  logic [7:0] nvec_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lvl;
    initial begin
        iack_o = 1'b0;
        iack_level_o = 3'h0;
        last_vector_o = 8'h00;
        nvec_o = 8'h00;
    end
    always begin
        @(posedge clk_i);
        if (!srst_i && (kick_i || (en_i && irq_level_i != 3'h0))) begin
            lvl = kick_i ? KICK_LEVEL : irq_level_i;
            if (slow_i) repeat (3) @(posedge clk_i);
            iack_o       <= 1'b1;
            iack_level_o <= wrong_i ? lvl ^ 3'h1 : lvl;
            @(posedge clk_i);
            // The level lines are not held outside a cycle, so they toggle.
            iack_o       <= 1'b0;
            iack_level_o <= ~iack_level_o;
            @(posedge clk_i);
            // every vector is taken, the error vector too
            if (vector_valid_i === 1'b1) begin
                last_vector_o <= vector_i;
                nvec_o        <= nvec_o + 8'h01;
            end
            @(posedge clk_i);
        end
    end
endmodule : host_core_model

`default_nettype wire

// ### prio_sel_if.sv
// Carrier between the controller registers and the priority selector.
`default_nettype none

interface prio_sel_if;
    logic [31:0] pending;
    logic [31:0] mask;
    logic [31:0] in_service;
    logic [23:0] cfg;
    logic        found;
    logic [4:0]  code;

    modport sel (input pending, input mask, input in_service, input cfg,
                 output found, output code);
    modport ctl (output pending, output mask, output in_service, output cfg,
                 input found, input code);
endinterface : prio_sel_if

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the communication interrupt controller.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, waitreq, vec_v, iack;
    logic        en = 1'b0, slow = 1'b0, wrong = 1'b0, kick = 1'b0, ce = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic [3:0]  be = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, src_ev = 32'h0, rv;
    logic [2:0]  iack_lvl, irq_lvl;
    logic [7:0]  vec, last_vec, nvec, k;
    int          miscompares = 0, cmp_count = 0;
    logic [23:0] cfgs [5] = '{24'h1B9FA0, 24'hE49FA0, 24'hE49FA1, 24'hE49FA0, 24'hE483A0};
    int          w1 [5] = '{27, 30, 9, 27, 3};
    int          w2 [5] = '{30, 27, 27, 9, 31};
    int          srcs [6] = '{31, 25, 16, 3, 1, 28};

    always #2 clk = ~clk;

    comm_intr_ctrl uut (.clk_sys_i(clk), .srst_i(srst), .ce_i(ce), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .src_event_i(src_ev),
        .iack_i(iack), .iack_level_i(iack_lvl), .irq_level_o(irq_lvl), .vector_o(vec),
        .vector_valid_o(vec_v));
    host_core_model core (.clk_i(clk), .srst_i(srst), .en_i(en), .slow_i(slow),
        .wrong_i(wrong), .kick_i(kick), .irq_level_i(irq_lvl), .vector_i(vec),
        .vector_valid_i(vec_v), .iack_o(iack), .iack_level_o(iack_lvl),
        .last_vector_o(last_vec), .nvec_o(nvec));

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    // Avalon access; the request stands until waitrequest is sampled low.
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) check("bus_answer", 32'h0, 32'h1);
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus

    task wait_vec(input logic [7:0] k0, input logic [7:0] exp);
        int n;
        n = 0;
        while (nvec === k0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check("vector", {24'h0, last_vec}, {24'h0, exp});
    endtask : wait_vec

    task ev(input logic [31:0] v);
        src_ev <= v;
        @(posedge clk);
        src_ev <= 32'h0;
        @(posedge clk);
    endtask : ev

    initial begin
        repeat (20000) @(posedge clk);
        check("watchdog", 32'h0, 32'h1);
        conclude;
    end

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(1'b0, comm_intr_pkg::OFF_CONFIG, 32'h0, 4'hF);
        check("cfg_reset", rv, 32'h0);
        check("level_reset", {29'h0, irq_lvl}, 32'h0);
        bus(1'b0, 5'h10, 32'h0, 4'hF);
        check("unmapped", rv, 32'h0);
        // Base lane left out, so the vector base stays unwritten.
        bus(1'b1, comm_intr_pkg::OFF_CONFIG, 32'h009F00, 4'hE);
        bus(1'b1, comm_intr_pkg::OFF_MASK, 32'h20, 4'hF);
        en <= 1'b1;
        k = nvec;
        ev(32'h20);
        wait_vec(k, comm_intr_pkg::UNINIT_VECTOR);
        bus(1'b0, comm_intr_pkg::OFF_IN_SVC, 32'h0, 4'hF);
        check("in_service", rv, 32'h20);
        bus(1'b1, comm_intr_pkg::OFF_IN_SVC, 32'h20, 4'hF);
        bus(1'b1, comm_intr_pkg::OFF_CONFIG, 32'h1B9FBE, 4'hF);
        bus(1'b0, comm_intr_pkg::OFF_CONFIG, 32'h0, 4'hF);
        check("cfg_rw", rv, 32'h1B9FA0);
        bus(1'b1, comm_intr_pkg::OFF_MASK, 32'hFFFFFFFF, 4'hF);
        for (int i = 0; i < 5; i++) begin
            // Rows never place one channel in two slots.
            bus(1'b1, comm_intr_pkg::OFF_CONFIG, {8'h0, cfgs[i]}, 4'hF);
            en <= 1'b0;
            ev((32'h1 << w1[i]) | (32'h1 << w2[i]));
            k = nvec;
            en <= 1'b1;
            wait_vec(k, 8'hA0 | w1[i]);
            k = nvec;
            bus(1'b0, comm_intr_pkg::OFF_PENDING, 32'h0, 4'hF);
            check("pending", rv, 32'h1 << w2[i]);
            bus(1'b1, comm_intr_pkg::OFF_IN_SVC, 32'h1 << w1[i], 4'hF);
            wait_vec(k, 8'hA0 | w2[i]);
            bus(1'b1, comm_intr_pkg::OFF_IN_SVC, 32'h1 << w2[i], 4'hF);
        end
        for (int i = 0; i < 6; i++) begin
            k = nvec;
            ev(32'h1 << srcs[i]);
            wait_vec(k, 8'hA0 | srcs[i]);
            bus(1'b1, comm_intr_pkg::OFF_IN_SVC, 32'h1 << srcs[i], 4'hF);
        end
        en <= 1'b0;
        bus(1'b1, comm_intr_pkg::OFF_MASK, 32'h0, 4'hF);
        ev(32'h400);
        repeat (3) @(posedge clk);
        check("masked_level", {29'h0, irq_lvl}, 32'h0);
        bus(1'b0, comm_intr_pkg::OFF_PENDING, 32'h0, 4'hF);
        check("masked_pending", rv, 32'h400);
        bus(1'b1, comm_intr_pkg::OFF_MASK, 32'h400, 4'hF);
        repeat (3) @(posedge clk);
        check("req_level", {29'h0, irq_lvl}, 32'h4);
        wrong <= 1'b1;
        k = nvec;
        en <= 1'b1;
        repeat (20) @(posedge clk);
        check("refused", {24'h0, nvec}, {24'h0, k});
        wrong <= 1'b0;
        slow <= 1'b1;
        wait_vec(k, 8'hAA);
        slow <= 1'b0;
        en <= 1'b0;
        bus(1'b1, comm_intr_pkg::OFF_IN_SVC, 32'h400, 4'hF);
        ev(32'h400);
        repeat (3) @(posedge clk);
        bus(1'b1, comm_intr_pkg::OFF_MASK, 32'h0, 4'hF);
        repeat (2) @(posedge clk);
        check("mask_drop", {29'h0, irq_lvl}, 32'h0);
        // A frozen block must not record an event that arrives meanwhile.
        ce <= 1'b0;
        ev(32'h2);
        ce <= 1'b1;
        bus(1'b0, comm_intr_pkg::OFF_PENDING, 32'h0, 4'hF);
        check("frozen_pending", rv, 32'h400);
        k = nvec;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        wait_vec(k, 8'hA0);
        conclude;
    end
endmodule : tb_top

`default_nettype wire
